// *** pgpc_pkg.sv ***
// Shared constants for the pin control block: register map, fields, codes, timing
package pgpc_pkg;
    localparam int unsigned NUM_PINS = 2;
    localparam int unsigned ADDR_W   = 18;
    localparam int unsigned CTRL_W   = 16;

    // Register indices; byte address is four times the index
    localparam logic [15:0] PIN_A_IDX      = 16'h4040;
    localparam logic [15:0] PIN_B_IDX      = 16'h4041;
    localparam logic [15:0] OUT_DATA_IDX   = 16'h4044;
    localparam logic [15:0] IRQ_STATUS_IDX = 16'h4048;
    localparam logic [15:0] IRQ_MASK_IDX   = 16'h4049;

    // Control register field positions
    localparam int unsigned DIR_BIT      = 15;
    localparam int unsigned PULL_HI      = 14;
    localparam int unsigned PULL_LO      = 13;
    localparam int unsigned IRQ_MODE_BIT = 12;
    localparam int unsigned DOMAIN_BIT   = 11;
    localparam int unsigned POL_BIT      = 10;
    localparam int unsigned OD_BIT       = 9;
    localparam int unsigned ENA_BIT      = 7;
    localparam int unsigned FN_HI        = 3;
    localparam int unsigned FN_LO        = 0;

    // Input, pull-down, non-inverted, digital I/O supply, disabled, function 0
    localparam logic [15:0] CTRL_RESET = 16'hA400;
    // Bits 8 and 6:4 are not implemented
    localparam logic [15:0] CTRL_WMASK = 16'hFE8F;
    localparam logic [15:0] OUT_RESET  = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;

    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h2;

    // Input function codes
    localparam logic [3:0] FN_IN_GPIO_LONG    = 4'h0;
    localparam logic [3:0] FN_IN_GPIO         = 4'h1;
    localparam logic [3:0] FN_IN_PWR_ONOFF    = 4'h2;
    localparam logic [3:0] FN_IN_SLEEP_WAKE   = 4'h3;
    localparam logic [3:0] FN_IN_SLEEP_WAKE_L = 4'h4;
    localparam logic [3:0] FN_IN_SLEEP        = 4'h5;
    localparam logic [3:0] FN_IN_PWR_ON       = 4'h6;
    localparam logic [3:0] FN_IN_WATCHDOG     = 4'h7;
    localparam logic [3:0] FN_IN_VSCALE_ONE   = 4'h8;
    localparam logic [3:0] FN_IN_VSCALE_TWO   = 4'h9;
    localparam logic [3:0] FN_IN_HW_EN_ONE    = 4'hA;
    localparam logic [3:0] FN_IN_HW_EN_TWO    = 4'hB;
    localparam logic [3:0] FN_IN_HW_CTL_ONE   = 4'hC;
    localparam logic [3:0] FN_IN_HW_CTL_TWO   = 4'hD;
    localparam logic [3:0] FN_IN_HW_CTL_ONE_L = 4'hE;
    localparam logic [3:0] FN_IN_HW_CTL_TWO_L = 4'hF;

    // Timing of the external power clock
    localparam int unsigned CLK_HZ     = 20_000_000;
    localparam int unsigned EXT_CLK_HZ = 2_000_000;
    localparam int unsigned EXT_HALF   = CLK_HZ / (2 * EXT_CLK_HZ);
endpackage

// *** pgpc_clkdiv.sv ***
// Divider that makes the external power clock from the system clock
`timescale 1ns/1ps
`default_nettype none
module pgpc_clkdiv (
    input  wire logic clk,
    input  wire logic rst,
    output logic      half_tick,
    output logic      ext_clk
);
    typedef struct packed {
        logic [2:0] count;
        logic       tick;
        logic       level;
    } pgpc_div_state_t;

    localparam logic [2:0] LAST = 3'(pgpc_pkg::EXT_HALF - 1);

    pgpc_div_state_t state;
    pgpc_div_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.tick = (state.count == LAST);
        if (state.count == LAST) begin
            next_state.count = 3'h0;
        end else begin
            next_state.count = state.count + 3'h1;
        end
        if (state.tick) begin
            next_state.level = ~state.level;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign half_tick = state.tick;
    assign ext_clk   = state.level;
endmodule
`default_nettype wire

// *** pgpc_pin.sv ***
// One pin: pad drive, pulls, polarity, function routing and edge detection
`timescale 1ns/1ps
`default_nettype none
module pgpc_pin (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] ctrl,
    input  wire logic [15:0] out_sources,
    input  wire logic        pad_in,
    output logic             pad_out,
    output logic             pad_oe,
    output logic             pull_up_en,
    output logic             pull_down_en,
    output logic             supply_domain_select,
    output logic [15:0]      in_func,
    output logic             edge_event
);
    typedef struct packed {
        logic        prev_level;
        logic        pad_out;
        logic        pad_oe;
        logic [15:0] in_func;
        logic        edge_event;
    } pgpc_pin_state_t;

    function automatic logic [15:0] onehot(input logic [3:0] code);
        onehot = 16'h0001 << code;
    endfunction

    pgpc_pin_state_t state;
    pgpc_pin_state_t next_state;

    logic       pin_enable;
    logic       pin_direction;
    logic       pin_polarity;
    logic       irq_edge_mode;
    logic       output_drive_type;
    logic [1:0] pull_select;
    logic [3:0] pin_function_select;

    assign pin_enable          = ctrl[pgpc_pkg::ENA_BIT];
    assign pin_direction       = ctrl[pgpc_pkg::DIR_BIT];
    assign pin_polarity        = ctrl[pgpc_pkg::POL_BIT];
    assign irq_edge_mode       = ctrl[pgpc_pkg::IRQ_MODE_BIT];
    assign output_drive_type   = ctrl[pgpc_pkg::OD_BIT];
    assign pull_select         = ctrl[pgpc_pkg::PULL_HI:pgpc_pkg::PULL_LO];
    assign pin_function_select = ctrl[pgpc_pkg::FN_HI:pgpc_pkg::FN_LO];

    always_comb begin
        logic level;
        logic value;
        logic in_active;
        logic drive;
        level     = 1'b0;
        value     = 1'b0;
        in_active = 1'b0;
        drive     = 1'b0;
        next_state = state;
        // RULE4: polarity applied to input
        level     = pad_in ^ ~pin_polarity;
        // RULE1: disabled pin is inert
        in_active = pin_enable & pin_direction;
        drive     = pin_enable & ~pin_direction;
        // RULE8: input function routing
        next_state.in_func = (in_active && level) ? onehot(pin_function_select) : 16'h0000;
        next_state.prev_level = level;
        // RULE5: single edge follows polarity
        next_state.edge_event = in_active & ~irq_edge_mode & level & ~state.prev_level;
        // RULE6: both edges in edge mode
        if (irq_edge_mode) begin
            next_state.edge_event = in_active & (level ^ state.prev_level);
        end
        // RULE12: output source by function
        value = out_sources[pin_function_select] ^ ~pin_polarity;
        // RULE2: CMOS or open-drain drive
        if (output_drive_type) begin
            next_state.pad_out = 1'b0;
            next_state.pad_oe  = drive & ~value;
        end else begin
            next_state.pad_out = value;
            next_state.pad_oe  = drive;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // RULE3: pull select; reserved code gives no pull
    assign pull_up_en   = pin_enable & (pull_select == pgpc_pkg::PULL_UP);
    assign pull_down_en = pin_enable & (pull_select == pgpc_pkg::PULL_DOWN);
    // RULE7: supply domain reference
    assign supply_domain_select = ctrl[pgpc_pkg::DOMAIN_BIT];
    assign pad_out    = state.pad_out;
    assign pad_oe     = state.pad_oe;
    assign in_func    = state.in_func;
    assign edge_event = state.edge_event;
endmodule
`default_nettype wire

// *** pgpc_top.sv ***
// Pin control block: Avalon-MM registers, two pins, routing and interrupt
// Behaviour
// RULE1: enable bit 7 tri-states pin when clear
// RULE2: bit 15 input/output; bit 9 open drain
// RULE3: pull field 14:13 none, down, up
// RULE4: polarity bit 10 sets active level
// RULE5: single edge follows polarity when mode clear
// RULE6: mode bit 12 set fires both edges
// RULE7: bit 11 picks pin supply domain
// RULE8: input codes 0,1 general input, debounce
// RULE9: input codes 2 to 6 power requests
// RULE10: codes 7,8,9 watchdog and voltage select
// RULE11: codes 10 to 15 hardware enable/control
// RULE12: output codes 0 to 4; 5-7 reserved
// RULE13: output codes 8 to 11 done, enables
// RULE14: codes 12 to 15 good, clock, reset
// RULE15: first pin control at index 4040h
// RULE16: second pin control at 4041h, same layout
// RULE17: unused bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module pgpc_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [17:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic [1:0]  pad_in,
    output logic [1:0]       pad_out,
    output logic [1:0]       pad_oe,
    output logic [1:0]       pull_up_en,
    output logic [1:0]       pull_down_en,
    output logic [1:0]       supply_domain_select,
    input  wire logic        osc_32k,
    input  wire logic        on_state,
    input  wire logic        sleep_state,
    input  wire logic        power_state_change,
    input  wire logic [1:0]  dvs_done,
    input  wire logic [1:0]  ext_power_enable,
    input  wire logic        system_supply_good,
    input  wire logic        converter_power_good,
    input  wire logic        aux_reset,
    output logic [1:0]       gpio_in_level,
    output logic [1:0]       long_debounce_req,
    output logic             power_onoff_req,
    output logic             sleep_wake_req,
    output logic             sleep_req,
    output logic             power_on_req,
    output logic             watchdog_reset_req,
    output logic             voltage_scale_select_one,
    output logic             voltage_scale_select_two,
    output logic [1:0]       hw_enable_req,
    output logic [1:0]       hw_control_req
);
    localparam int unsigned NP = pgpc_pkg::NUM_PINS;

    typedef struct packed {
        logic [NP-1:0][15:0] ctrl;
        logic [NP-1:0]       out_data;
        logic [NP-1:0]       irq_status;
        logic [NP-1:0]       irq_mask;
        logic                ack;
        logic [31:0]         readdata;
    } pgpc_top_state_t;

    // Aligned word at the given register index
    function automatic logic hit(input logic [17:0] addr, input logic [15:0] idx);
        hit = (addr[17:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    // Byte-lane merge limited to the implemented bits
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wdata,
                                          input logic [1:0]  be,
                                          input logic [15:0] implemented);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & implemented;
        merge = (old & ~lanes) | (wdata & lanes);
    endfunction

    pgpc_top_state_t state;
    pgpc_top_state_t next_state;

    logic                req;
    logic                wr;
    logic                ext_clk;
    logic [NP-1:0]       edge_event;
    logic [NP-1:0][15:0] in_func;
    logic [NP-1:0][15:0] out_sources;
    logic [15:0]         in_any;
    logic [15:0]         pin_mask;

    assign req      = avs_read | avs_write;
    // Writes land on the edge at which waitrequest is seen low
    assign wr       = avs_write & state.ack;
    assign pin_mask = 16'((1 << NP) - 1);

    always_comb begin
        logic [31:0] rd;
        logic [15:0] clear;
        rd    = 32'h0000_0000;
        clear = 16'h0000;
        next_state = state;

        // One wait state: request seen, then answered
        next_state.ack = req & ~state.ack;

        // RULE15: first pin control decode
        if (hit(avs_address, pgpc_pkg::PIN_A_IDX)) begin
            rd[15:0] = state.ctrl[0];
        end
        // RULE16: second pin control decode
        if (hit(avs_address, pgpc_pkg::PIN_B_IDX)) begin
            rd[15:0] = state.ctrl[1];
        end
        if (hit(avs_address, pgpc_pkg::OUT_DATA_IDX)) begin
            rd[NP-1:0] = state.out_data;
        end
        if (hit(avs_address, pgpc_pkg::IRQ_STATUS_IDX)) begin
            rd[NP-1:0] = state.irq_status;
        end
        if (hit(avs_address, pgpc_pkg::IRQ_MASK_IDX)) begin
            rd[NP-1:0] = state.irq_mask;
        end
        if (avs_read && !state.ack) begin
            next_state.readdata = rd;
        end

        if (wr) begin
            // RULE17: unused bits never stored
            if (hit(avs_address, pgpc_pkg::PIN_A_IDX)) begin
                next_state.ctrl[0] = merge(state.ctrl[0], avs_writedata[15:0],
                                           avs_byteenable[1:0], pgpc_pkg::CTRL_WMASK);
            end
            if (hit(avs_address, pgpc_pkg::PIN_B_IDX)) begin
                next_state.ctrl[1] = merge(state.ctrl[1], avs_writedata[15:0],
                                           avs_byteenable[1:0], pgpc_pkg::CTRL_WMASK);
            end
            if (hit(avs_address, pgpc_pkg::OUT_DATA_IDX)) begin
                next_state.out_data = NP'(merge(16'(state.out_data), avs_writedata[15:0],
                                                avs_byteenable[1:0], pin_mask));
            end
            if (hit(avs_address, pgpc_pkg::IRQ_MASK_IDX)) begin
                next_state.irq_mask = NP'(merge(16'(state.irq_mask), avs_writedata[15:0],
                                                avs_byteenable[1:0], pin_mask));
            end
            if (hit(avs_address, pgpc_pkg::IRQ_STATUS_IDX) && avs_byteenable[0]) begin
                clear = avs_writedata[15:0] & pin_mask;
            end
        end
        // A new edge in the clearing cycle survives the clear
        next_state.irq_status = (state.irq_status & ~clear[NP-1:0]) | edge_event;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state.ctrl       <= {NP{pgpc_pkg::CTRL_RESET}};
            state.out_data   <= NP'(pgpc_pkg::OUT_RESET);
            state.irq_status <= '0;
            state.irq_mask   <= NP'(pgpc_pkg::MASK_RESET);
            state.ack        <= 1'b0;
            state.readdata   <= 32'h0000_0000;
        end else begin
            state <= next_state;
        end
    end

    assign avs_waitrequest = req & ~state.ack;
    assign avs_readdata    = state.readdata;
    assign irq             = |(state.irq_status & state.irq_mask);

    // RULE14: external power clock from the divider
    pgpc_clkdiv u_clkdiv (
        .clk       (clk),
        .rst       (rst),
        .half_tick (),
        .ext_clk   (ext_clk)
    );

    for (genvar p = 0; p < NP; p++) begin : g_pin
        // RULE13: converter done and power enable sources
        assign out_sources[p] = {aux_reset, ext_clk, converter_power_good, system_supply_good,
                                 ext_power_enable[1], ext_power_enable[0],
                                 dvs_done[1], dvs_done[0], 3'h0,
                                 power_state_change, sleep_state, on_state, osc_32k,
                                 state.out_data[p]};

        pgpc_pin u_pin (
            .clk                  (clk),
            .rst                  (rst),
            .ctrl                 (state.ctrl[p]),
            .out_sources          (out_sources[p]),
            .pad_in               (pad_in[p]),
            .pad_out              (pad_out[p]),
            .pad_oe               (pad_oe[p]),
            .pull_up_en           (pull_up_en[p]),
            .pull_down_en         (pull_down_en[p]),
            .supply_domain_select (supply_domain_select[p]),
            .in_func              (in_func[p]),
            .edge_event           (edge_event[p])
        );

        // RULE8: long debounce asked for codes 0, 4, 14, 15
        assign long_debounce_req[p] = state.ctrl[p][3:0] inside {
            pgpc_pkg::FN_IN_GPIO_LONG, pgpc_pkg::FN_IN_SLEEP_WAKE_L,
            pgpc_pkg::FN_IN_HW_CTL_ONE_L, pgpc_pkg::FN_IN_HW_CTL_TWO_L};

        assign gpio_in_level[p] = in_func[p][pgpc_pkg::FN_IN_GPIO_LONG] |
                                  in_func[p][pgpc_pkg::FN_IN_GPIO];
    end

    // Requests from both pins OR together
    always_comb begin
        in_any = 16'h0000;
        for (int i = 0; i < NP; i++) begin
            in_any = in_any | in_func[i];
        end
    end

    // RULE9: power and sleep requests
    assign power_onoff_req = in_any[pgpc_pkg::FN_IN_PWR_ONOFF];
    assign sleep_wake_req  = in_any[pgpc_pkg::FN_IN_SLEEP_WAKE] |
                             in_any[pgpc_pkg::FN_IN_SLEEP_WAKE_L];
    assign sleep_req       = in_any[pgpc_pkg::FN_IN_SLEEP];
    assign power_on_req    = in_any[pgpc_pkg::FN_IN_PWR_ON];
    // RULE10: watchdog and voltage selects
    assign watchdog_reset_req       = in_any[pgpc_pkg::FN_IN_WATCHDOG];
    assign voltage_scale_select_one = in_any[pgpc_pkg::FN_IN_VSCALE_ONE];
    assign voltage_scale_select_two = in_any[pgpc_pkg::FN_IN_VSCALE_TWO];
    // RULE11: hardware enables and controls
    assign hw_enable_req  = {in_any[pgpc_pkg::FN_IN_HW_EN_TWO], in_any[pgpc_pkg::FN_IN_HW_EN_ONE]};
    assign hw_control_req = {in_any[pgpc_pkg::FN_IN_HW_CTL_TWO] | in_any[pgpc_pkg::FN_IN_HW_CTL_TWO_L],
                             in_any[pgpc_pkg::FN_IN_HW_CTL_ONE] | in_any[pgpc_pkg::FN_IN_HW_CTL_ONE_L]};
endmodule
`default_nettype wire

// *** pgpc_props.sv ***
// Port-level checker for the pin control block
`timescale 1ns/1ps
`default_nettype none
module pgpc_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic        irq,
    input wire logic [1:0]  pad_in,
    input wire logic [1:0]  pull_up_en,
    input wire logic [1:0]  pull_down_en,
    input wire logic [1:0]  supply_domain_select,
    input wire logic [1:0]  long_debounce_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic       req;
    logic       acc;
    logic [1:0] pad_q;
    logic [2:0] quiet;
    assign req = avs_read | avs_write;
    assign acc = avs_write & ~avs_waitrequest;
    // Cycles since last write or pad change; saturates
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_q <= 2'h0;
            quiet <= 3'h7;
        end else begin
            pad_q <= pad_in;
            quiet <= (acc || pad_in != pad_q) ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
        end
    end
    wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("answer late");
    wait_idle_a: assert property (!req |-> !avs_waitrequest)
        else $error("wait while idle");
    wait_again_a: assert property (req && !avs_waitrequest ##1 req |-> avs_waitrequest)
        else $error("no second wait");
    rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved");
    pull_excl_a: assert property ((pull_up_en & pull_down_en) == 2'h0)
        else $error("both pulls on");
    pull_cfg_a: assert property ($changed({pull_up_en, pull_down_en}) |-> $past(acc))
        else $error("pull moved");
    domain_cfg_a: assert property ($changed(supply_domain_select) |-> $past(acc))
        else $error("domain moved");
    debounce_cfg_a: assert property ($changed(long_debounce_req) |-> $past(acc))
        else $error("debounce moved");
    irq_fall_a: assert property ($fell(irq) |-> $past(acc))
        else $error("irq dropped");
    irq_rise_a: assert property ($rose(irq) |-> quiet <= 3'h5)
        else $error("irq rose");
    cover property (acc);
    cover property ($rose(irq));
    cover property (pull_up_en[0] ##1 pull_down_en[0]);
endmodule
bind pgpc_top pgpc_props pgpc_props_inst (.clk(clk), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .irq(irq), .pad_in(pad_in), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .supply_domain_select(supply_domain_select), .long_debounce_req(long_debounce_req));
`default_nettype wire

// *** pgpc_pad_model.sv ***
// Board-side model of the two pins: outside driver, pulls and floating level
`timescale 1ns/1ps
`default_nettype none
module pgpc_pad_model (
    input  wire logic       clk,
    input  wire logic [1:0] pad_out,
    input  wire logic [1:0] pad_oe,
    input  wire logic [1:0] pull_up_en,
    input  wire logic [1:0] pull_down_en,
    input  wire logic [1:0] ext_en,
    input  wire logic [1:0] ext_val,
    output logic [1:0]      pad_level
);
    logic [1:0] last = 2'h0;
    // Floating pin toggles each cycle
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pad_level[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : ~last[i];
        end
    end
    always_ff @(posedge clk) last <= pad_level;
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, irq;
    logic [17:0] avs_address = 18'h0_0000;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] srcs = 16'h0000;
    logic [1:0]  ext_en = 2'h0, ext_val = 2'h0, pad_level, pad_out, pad_oe, pull_up_en;
    logic [1:0]  pull_down_en, sdom, gin, ldb, hwe, hwc;
    logic [6:0]  misc;
    int          errors = 0, compares = 0;
    initial forever #25 clk = ~clk;
    pgpc_top pgpc_top_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .pad_in(pad_level), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .supply_domain_select(sdom),
        .osc_32k(srcs[1]), .on_state(srcs[2]), .sleep_state(srcs[3]),
        .power_state_change(srcs[4]), .dvs_done(srcs[9:8]), .ext_power_enable(srcs[11:10]),
        .system_supply_good(srcs[12]), .converter_power_good(srcs[13]), .aux_reset(srcs[15]),
        .gpio_in_level(gin), .long_debounce_req(ldb), .power_onoff_req(misc[0]),
        .sleep_wake_req(misc[1]), .sleep_req(misc[2]), .power_on_req(misc[3]),
        .watchdog_reset_req(misc[4]), .voltage_scale_select_one(misc[5]),
        .voltage_scale_select_two(misc[6]), .hw_enable_req(hwe), .hw_control_req(hwc));
    pgpc_pad_model pgpc_pad_model_inst (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
        .ext_val(ext_val), .pad_level(pad_level));

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic rd, input logic [15:0] idx, d, output logic [15:0] q);
        int n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'h0};
        avs_read <= rd;
        avs_write <= ~rd;
        avs_writedata <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) errors++;
    endtask
    task automatic wr(input logic [15:0] idx, d);
        logic [15:0] q;
        bus(1'b0, idx, d, q);
    endtask
    task automatic rdchk(input string nm, input logic [15:0] idx, exp);
        logic [15:0] q;
        bus(1'b1, idx, 16'h0000, q);
        chk(nm, q, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [15:0] b(input logic x);
        return {15'h0000, x};
    endfunction
    logic [10:0] fexp [16] = '{11'h000, 11'h000, 11'h001, 11'h002, 11'h002, 11'h004, 11'h008,
        11'h010, 11'h020, 11'h040, 11'h080, 11'h100, 11'h200, 11'h400, 11'h200, 11'h400};

    task automatic t_map;
        rdchk("ctrl_a", 16'h4040, 16'hA400);
        rdchk("ctrl_b", 16'h4041, 16'hA400);
        rdchk("unmapped", 16'h4050, 16'h0000);
        wr(16'h4040, 16'hFFFF);
        wr(16'h4041, 16'hFFFF);
        rdchk("ctrl_a_fill", 16'h4040, 16'hFE8F);
        rdchk("ctrl_b_fill", 16'h4041, 16'hFE8F);
        chk("domain_hi", {14'h0000, sdom}, 16'h0003);
        wr(16'h4040, 16'hA400);
        wr(16'h4041, 16'hA400);
        settle;
        chk("domain_lo", {14'h0000, sdom}, 16'h0000);
    endtask
    task automatic t_pull;
        for (int p = 0; p < 4; p++) begin
            wr(16'h4040, {1'b1, p[1:0], 13'h0481});
            settle;
            chk("pull_up", b(pull_up_en[0]), b(p == 2));
            chk("pull_down", b(pull_down_en[0]), b(p == 1));
        end
        wr(16'h4041, 16'hC481);
        settle;
        chk("pull_up_b", b(pull_up_en[1]), 16'h0001);
    endtask
    task automatic t_irq;
        logic [3:0] tb [6] = '{4'hB, 4'h8, 4'h1, 4'h2, 4'hD, 4'h7};
        logic [3:0] t;
        ext_en <= 2'h1;
        for (int i = 0; i < 6; i++) begin
            t = tb[i];
            ext_val <= {1'b0, ~t[1]};
            wr(16'h4040, {3'h5, t[2], 1'b0, t[3], 10'h081});
            wr(16'h4049, 16'h0001);
            wr(16'h4048, 16'h0003);
            @(posedge clk);
            ext_val <= {1'b0, t[1]};
            repeat (4) @(posedge clk);
            rdchk("status", 16'h4048, {15'h0000, t[0]});
            chk("irq", b(irq), b(t[0]));
            chk("in_level", b(gin[0]), b(t[1] ^ ~t[3]));
        end
        wr(16'h4049, 16'h0000);
        settle;
        chk("irq_masked", b(irq), 16'h0000);
        wr(16'h4048, 16'h0001);
        rdchk("status_clr", 16'h4048, 16'h0000);
    endtask
    task automatic t_infunc;
        for (int c = 0; c < 16; c++) begin
            ext_val <= 2'h1;
            wr(16'h4040, {12'hA48, c[3:0]});
            settle;
            chk("in_func", {5'h00, hwc, hwe, misc}, {5'h00, fexp[c]});
            chk("debounce", b(ldb[0]), b(c inside {0, 4, 14, 15}));
            ext_val <= 2'h0;
            settle;
            chk("in_idle", {5'h00, hwc, hwe, misc}, 16'h0000);
        end
        ext_en <= 2'h0;
    endtask
    task automatic t_outfunc;
        int n = 0;
        logic p;
        for (int c = 0; c < 16; c++) begin
            for (int v = 0; v < 2; v++) begin
                if (c != 14) begin
                    srcs <= v ? (16'h0001 << c) : ~(16'h0001 << c);
                    wr(16'h4044, (c == 0 && v == 1) ? 16'h0001 : 16'h0000);
                    wr(16'h4040, {12'h248, c[3:0]});
                    settle;
                    p = v == 1 && !(c inside {[5:7]});
                    chk("out_val", b(pad_out[0]), b(p));
                    chk("out_oe", b(pad_oe[0]), 16'h0001);
                end
            end
        end
        wr(16'h4040, 16'h248E);
        settle;
        p = pad_out[0];
        // Eight toggles in forty cycles
        repeat (40) begin
            @(posedge clk);
            if (pad_out[0] !== p) n++;
            p = pad_out[0];
        end
        chk("ext_clk", n[15:0], 16'h0008);
        wr(16'h4040, 16'h2085);
        settle;
        chk("out_inv", b(pad_out[0]), 16'h0001);
        wr(16'h4040, 16'h2400);
        settle;
        chk("out_off", b(pad_oe[0]), 16'h0000);
        for (int v = 0; v < 2; v++) begin
            wr(16'h4044, v[15:0]);
            // Pull-up gives the released open-drain pin its high level
            wr(16'h4040, 16'h4680);
            settle;
            chk("od_oe", b(pad_oe[0]), b(v == 0));
            chk("od_level", b(pad_level[0]), v[15:0]);
        end
    endtask

    task automatic print_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_map;
        t_pull;
        t_irq;
        t_infunc;
        t_outfunc;
        print_verdict;
    end
endmodule
`default_nettype wire
